// ==== rtl/tsr_slave_rx.sv ====
// two-wire slave receiver with avalon-mm register access and interrupt
// assumes open-drain pins resolved outside; bus master follows avalon-mm
//
// Added by the designer: the Avalon-MM slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "tsr_defines.svh"
module tsr_slave_rx (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // avalon-mm slave
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // interrupt
  output logic irq,
  // clock line
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  // data line
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // queued start handed to the master side
  output logic start_launch
);
  import tsr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic scl_f;
  logic sda_f;
  logic scl_q;
  logic sda_q;
  logic ack_q;
  logic next_ack_q;
  logic [31:0] next_readdata;
  tsr_pkg::tsr_state_t state;
  tsr_pkg::tsr_state_t next_state;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic [7:0] data_reg;
  logic [7:0] next_data_reg;
  logic [7:0] status;
  logic [7:0] next_status;
  logic [7:0] own_reg;
  logic [7:0] next_own_reg;
  logic [7:0] rate_reg;
  logic [7:0] next_rate_reg;
  logic flag;
  logic next_flag;
  logic ack_en;
  logic next_ack_en;
  logic start_req;
  logic next_start_req;
  logic stop_req;
  logic next_stop_req;
  logic if_en;
  logic next_if_en;
  logic ack_dec;
  logic next_ack_dec;
  logic gc;
  logic next_gc;
  logic restart;
  logic next_restart;
  logic pend;
  logic next_pend;
  logic busy;
  logic next_busy;
  logic sda_low;
  logic next_sda_low;
  logic scl_hold;
  logic next_scl_hold;
  logic next_launch;
  logic pend_launch_q;
  logic [1:0] irq_stat;
  logic [1:0] next_irq_stat;
  logic [1:0] irq_mask;
  logic [1:0] next_irq_mask;
  logic set_flag;
  logic clr_flag;
  logic wr_go;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic [1:0] hit;

  // address recognition: bit 1 own address with write, bit 0 general call
  function automatic logic [1:0] addr_hit(input logic [7:0] rx, input logic [7:0] own,
                                          input logic ack);
    logic own_hit;
    logic gc_hit;
    own_hit = ack && (rx[7:1] == own[7:1]) && !rx[0];
    gc_hit = ack && own[`TSR_OWN_GCE] && (rx == `TSR_GCA);
    return {own_hit, gc_hit};
  endfunction : addr_hit

  // terminal codes lead back to the not addressed state
  function automatic logic is_terminal(input logic [7:0] code);
    return (code == `TSR_ST_DATA_NACK) || (code == `TSR_ST_GC_NACK) ||
           (code == `TSR_ST_STOP);
  endfunction : is_terminal

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser

  tsr_sync #(
    .WIDTH(2),
    .RESET_VAL(2'h3)
  ) u_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .async_in({scl_in, sda_in}),
    .filt_out({scl_f, sda_f})
  );

  // line events from filtered levels
  assign scl_rise = scl_f && !scl_q;
  assign scl_fall = !scl_f && scl_q;
  assign start_ev = scl_f && scl_q && sda_q && !sda_f;
  assign stop_ev = scl_f && scl_q && !sda_q && sda_f;

  // open-drain drives, low level only
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_n = !scl_hold;
  assign sda_oe_n = !sda_low;
  assign start_launch = pend_launch_q;
  assign irq = |(irq_stat & irq_mask);

  ////////////////////////////////////////////////////////////////////////////
  // avalon-mm slave: one wait cycle, answer in the second

  assign waitrequest = (read || write) && !ack_q;
  assign wr_go = write && ack_q && byteenable[0];

  // read data latched in the wait cycle, unmapped reads give zero
  always_comb begin
    next_ack_q = (read || write) && !ack_q;
    next_readdata = readdata;
    if (read && !ack_q) begin
      next_readdata = 32'h0000_0000;
      if (address == `TSR_REG_CTRL) begin
        next_readdata[7:0] = {flag, ack_en, start_req, stop_req, 1'b0, if_en, 2'b00};
      end else if (address == `TSR_REG_STATUS) begin
        next_readdata[7:0] = status;
      end else if (address == `TSR_REG_DATA) begin
        next_readdata[7:0] = data_reg;
      end else if (address == `TSR_REG_OWN) begin
        next_readdata[7:0] = own_reg;
      end else if (address == `TSR_REG_RATE) begin
        next_readdata[7:0] = rate_reg;
      end else if (address == `TSR_REG_IRQ_STAT) begin
        next_readdata[1:0] = irq_stat;
      end else if (address == `TSR_REG_IRQ_MASK) begin
        next_readdata[1:0] = irq_mask;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ack_q <= 1'b0;
      readdata <= 32'h0000_0000;
    end else begin
      ack_q <= next_ack_q;
      readdata <= next_readdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receiver, control registers and interrupt status

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_shift = shift;
    next_data_reg = data_reg;
    next_status = status;
    next_own_reg = own_reg;
    next_rate_reg = rate_reg;
    next_ack_en = ack_en;
    next_start_req = start_req;
    next_stop_req = stop_req;
    next_if_en = if_en;
    next_ack_dec = ack_dec;
    next_gc = gc;
    next_restart = restart;
    next_pend = pend;
    next_busy = busy;
    next_sda_low = sda_low;
    next_launch = 1'b0;
    next_irq_mask = irq_mask;
    set_flag = 1'b0;
    clr_flag = 1'b0;
    hit = addr_hit(shift, own_reg, ack_en);
    // register writes; software enables with flag, ack and enable set
    next_irq_stat = irq_stat;
    if (wr_go) begin
      if (address == `TSR_REG_CTRL) begin
        next_ack_en = writedata[`TSR_CTRL_ACK];
        next_start_req = writedata[`TSR_CTRL_START];
        next_stop_req = writedata[`TSR_CTRL_STOP];
        next_if_en = writedata[`TSR_CTRL_EN];
        clr_flag = writedata[`TSR_CTRL_FLAG];
      end else if (address == `TSR_REG_OWN) begin
        next_own_reg = writedata[7:0];
      end else if (address == `TSR_REG_RATE) begin
        next_rate_reg = writedata[7:0];
      end else if (address == `TSR_REG_IRQ_STAT) begin
        next_irq_stat = irq_stat & ~writedata[1:0];
      end else if (address == `TSR_REG_IRQ_MASK) begin
        next_irq_mask = writedata[1:0];
      end
    end
    // bus free tracking and queued start
    if (start_ev) begin
      next_busy = 1'b1;
    end else if (stop_ev) begin
      next_busy = 1'b0;
    end
    if (pend && !busy && !start_ev) begin
      next_launch = 1'b1;
      next_pend = 1'b0;
    end
    // receiver state machine
    case (state)
      tsr_idle: begin
        next_sda_low = 1'b0;
        if (start_ev && if_en) begin
          next_state = tsr_addr;
          next_cnt = 4'h0;
        end
      end
      tsr_addr: begin
        if (stop_ev) begin
          next_state = tsr_idle;
        end else if (start_ev) begin
          next_cnt = 4'h0;
        end else if (scl_rise) begin
          next_shift = {shift[6:0], sda_f};
          next_cnt = cnt + 4'h1;
        end else if (scl_fall && cnt == 4'h8) begin
          if (hit != 2'b00) begin
            next_gc = !hit[1];
            next_sda_low = 1'b1;
            next_state = tsr_addr_ack;
          end else begin
            next_state = tsr_idle;
          end
        end
      end
      tsr_addr_ack: begin
        if (scl_fall) begin
          next_sda_low = 1'b0;
          set_flag = 1'b1;
          next_status = gc ? `TSR_ST_GCA_ACK : `TSR_ST_SLA_ACK;
          next_restart = 1'b0;
          next_state = tsr_hold;
        end
      end
      tsr_hold: begin
        if (start_ev && status == `TSR_ST_STOP) begin
          next_restart = 1'b1;
        end
        if (!flag) begin
          next_cnt = 4'h0;
          if (is_terminal(status)) begin
            next_pend = start_req;
            next_state = (status == `TSR_ST_STOP && restart) ? tsr_addr : tsr_idle;
          end else begin
            next_ack_dec = ack_en;
            next_state = tsr_data;
          end
        end
      end
      tsr_data: begin
        if (stop_ev || start_ev) begin
          set_flag = 1'b1;
          next_status = `TSR_ST_STOP;
          next_restart = start_ev;
          next_state = tsr_hold;
        end else if (scl_rise) begin
          next_shift = {shift[6:0], sda_f};
          next_cnt = cnt + 4'h1;
        end else if (scl_fall && cnt == 4'h8) begin
          next_sda_low = ack_dec;
          next_state = tsr_data_ack;
        end
      end
      tsr_data_ack: begin
        if (stop_ev || start_ev) begin
          next_sda_low = 1'b0;
          set_flag = 1'b1;
          next_status = `TSR_ST_STOP;
          next_restart = start_ev;
          next_state = tsr_hold;
        end else if (scl_fall) begin
          next_sda_low = 1'b0;
          next_data_reg = shift;
          set_flag = 1'b1;
          if (gc) begin
            next_status = ack_dec ? `TSR_ST_GC_ACK : `TSR_ST_GC_NACK;
          end else begin
            next_status = ack_dec ? `TSR_ST_DATA_ACK : `TSR_ST_DATA_NACK;
          end
          next_state = tsr_hold;
        end
      end
      default: begin
        next_state = tsr_idle;
      end
    endcase
    // disabled interface releases the lines
    if (!if_en) begin
      next_state = tsr_idle;
      next_sda_low = 1'b0;
    end
    // hardware set wins over a software clear
    next_flag = set_flag ? 1'b1 : (clr_flag ? 1'b0 : flag);
    if (set_flag) begin
      next_irq_stat[`TSR_IRQ_DONE] = 1'b1;
    end
    if (next_launch) begin
      next_irq_stat[`TSR_IRQ_START] = 1'b1;
    end
    // stretch a low clock while waiting for software, except after a stop;
    // after a start the pull waits for the master's own clock fall
    next_scl_hold = (next_state == tsr_hold) && next_flag && !scl_f &&
                    !(next_status == `TSR_ST_STOP && !next_restart);
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      state <= tsr_idle;
      cnt <= 4'h0;
      shift <= `TSR_RST_BYTE;
      data_reg <= `TSR_RST_BYTE;
      status <= `TSR_ST_IDLE;
      own_reg <= `TSR_RST_BYTE;
      rate_reg <= `TSR_RST_BYTE;
      flag <= 1'b0;
      ack_en <= 1'b0;
      start_req <= 1'b0;
      stop_req <= 1'b0;
      if_en <= 1'b0;
      ack_dec <= 1'b0;
      gc <= 1'b0;
      restart <= 1'b0;
      pend <= 1'b0;
      busy <= 1'b0;
      sda_low <= 1'b0;
      scl_hold <= 1'b0;
      pend_launch_q <= 1'b0;
      irq_stat <= `TSR_RST_IRQ;
      irq_mask <= `TSR_RST_IRQ;
    end else begin
      scl_q <= scl_f;
      sda_q <= sda_f;
      state <= next_state;
      cnt <= next_cnt;
      shift <= next_shift;
      data_reg <= next_data_reg;
      status <= next_status;
      own_reg <= next_own_reg;
      rate_reg <= next_rate_reg;
      flag <= next_flag;
      ack_en <= next_ack_en;
      start_req <= next_start_req;
      stop_req <= next_stop_req;
      if_en <= next_if_en;
      ack_dec <= next_ack_dec;
      gc <= next_gc;
      restart <= next_restart;
      pend <= next_pend;
      busy <= next_busy;
      sda_low <= next_sda_low;
      scl_hold <= next_scl_hold;
      pend_launch_q <= next_launch;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
    end
  end

endmodule : tsr_slave_rx
`default_nettype wire

// ==== rtl/tsr_defines.svh ====
// register offsets, field positions, reset values and status codes of the
// two-wire slave receiver; assumes byte addresses on a 32-bit avalon-mm bus
`ifndef TSR_DEFINES_SVH
`define TSR_DEFINES_SVH

// register byte offsets
`define TSR_REG_CTRL 5'h00
`define TSR_REG_STATUS 5'h04
`define TSR_REG_DATA 5'h08
`define TSR_REG_OWN 5'h0c
`define TSR_REG_RATE 5'h10
`define TSR_REG_IRQ_STAT 5'h14
`define TSR_REG_IRQ_MASK 5'h18

// bus_control_reg fields
`define TSR_CTRL_FLAG 7
`define TSR_CTRL_ACK 6
`define TSR_CTRL_START 5
`define TSR_CTRL_STOP 4
`define TSR_CTRL_EN 2

// own_address_reg fields
`define TSR_OWN_GCE 0

// interrupt status and mask fields
`define TSR_IRQ_DONE 0
`define TSR_IRQ_START 1

// reset values
`define TSR_RST_BYTE 8'h00
`define TSR_RST_IRQ 2'h0

// status codes
`define TSR_ST_IDLE 8'hf8
`define TSR_ST_SLA_ACK 8'h60
`define TSR_ST_GCA_ACK 8'h70
`define TSR_ST_DATA_ACK 8'h80
`define TSR_ST_DATA_NACK 8'h88
`define TSR_ST_GC_ACK 8'h90
`define TSR_ST_GC_NACK 8'h98
`define TSR_ST_STOP 8'ha0

// the general call address byte
`define TSR_GCA 8'h00

`endif

// ==== rtl/tsr_pkg.sv ====
// types shared by the two-wire slave receiver
// assumes nothing of its surroundings
`default_nettype none
package tsr_pkg;
  // receiver states
  typedef enum logic [2:0] {
    tsr_idle,
    tsr_addr,
    tsr_addr_ack,
    tsr_hold,
    tsr_data,
    tsr_data_ack
  } tsr_state_t;
endpackage : tsr_pkg
`default_nettype wire

// ==== rtl/tsr_sync.sv ====
// pin input synchroniser with agreement filter
// assumes inputs asynchronous to core_clk
`timescale 1ns/100ps
`default_nettype none
module tsr_sync #(
  parameter int WIDTH = 2,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // raw and filtered levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] filt_out
);

  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  logic [WIDTH-1:0] next_filt;

  // filtered level moves only when stages two and three agree
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      assign next_filt[i] = (s2[i] == s3[i]) ? s3[i] : filt_out[i];
    end
  endgenerate

  // three stage chain, first stage read only by the second
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s1 <= RESET_VAL;
      s2 <= RESET_VAL;
      s3 <= RESET_VAL;
      filt_out <= RESET_VAL;
    end else begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
      filt_out <= next_filt;
    end
  end

endmodule : tsr_sync
`default_nettype wire

// ==== rtl/tsr_slave_rx_fix.sv ====
// spare source slot of the two-wire slave receiver; holds no logic
// assumes the receiver and its synchroniser come from their own files

// ==== dv/tsr_slave_rx_assertions.sv ====
// port-level checker for the two-wire slave receiver
// assumes it is bound to tsr_slave_rx and sees only its ports
`timescale 1ns/100ps
`default_nettype none
module tsr_slave_rx_assertions (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // register bus and interrupt
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  input wire logic irq,
  // two-wire lines
  input wire logic scl_in,
  input wire logic scl_oe_n,
  input wire logic sda_in,
  input wire logic sda_oe_n,
  input wire logic start_launch
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////
  // bus answers after exactly one wait state
  a_bus_first_wait: assert property ($rose(read || write) |-> waitrequest)
    else $error("no wait state on new request");
  a_bus_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus answer late");
  // interrupt only drops after a software write
  a_irq_drop: assert property ($fell(irq) |-> $past(write))
    else $error("irq dropped without a write");
  // ack is driven only while the clock line is low, and held while it is high
  a_ack_start_low: assert property ($fell(sda_oe_n) |-> !scl_in)
    else $error("ack started with clock high");
  a_sda_steady_high: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe_n))
    else $error("data pull changed with clock high");
  // stretch starts on a low clock and ends only two to four cycles after a write
  a_stretch_start: assert property ($fell(scl_oe_n) |-> !scl_in)
    else $error("stretch began with clock high");
  a_stretch_end: assert property ($rose(scl_oe_n) |->
    $past(write, 2) || $past(write, 3) || $past(write, 4))
    else $error("stretch released without a write");
  // queued start handed on as a single pulse on a free bus
  a_launch_pulse: assert property (start_launch |=> !start_launch)
    else $error("start launch longer than a cycle");
  a_launch_free: assert property (start_launch |-> scl_in && sda_in && scl_oe_n && sda_oe_n)
    else $error("start launch on a busy bus");
  // main scenarios
  c_ack: cover property ($fell(sda_oe_n));
  c_stretch: cover property ($fell(scl_oe_n));
  c_launch: cover property (start_launch);
  c_irq_clear: cover property ($fell(irq));
endmodule : tsr_slave_rx_assertions

bind tsr_slave_rx tsr_slave_rx_assertions u_chk (.core_clk(core_clk), .nrst(nrst),
  .read(read), .write(write), .waitrequest(waitrequest), .irq(irq), .scl_in(scl_in),
  .scl_oe_n(scl_oe_n), .sda_in(sda_in), .sda_oe_n(sda_oe_n), .start_launch(start_launch));
`default_nettype wire

// ==== dv/tsr_master_model.sv ====
// remote two-wire bus master that writes bytes to the slave
// assumes open-drain lines resolved by the bench with pull-ups
`timescale 1ns/100ps
`default_nettype none
module tsr_master_model (
  // clock
  input wire logic core_clk,
  // resolved line levels
  input wire logic scl,
  input wire logic sda,
  // pulls, high drives the line low
  output logic scl_low,
  output logic sda_low,
  // a stretch outlasted the wait bound
  output logic stuck
);
  localparam int HALF = 8; // third of a bit in clocks, without the rise wait
  ////////////////////////////////////////////////////////////////
  // idle bus at start
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    stuck = 1'b0;
  end
  // a fixed pause
  task automatic hb();
    repeat (HALF) @(posedge core_clk);
  endtask : hb
  // release the clock and wait while the slave stretches it
  task automatic rise();
    int n;
    scl_low <= 1'b0;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (scl !== 1'b1 && n < 5000);
    if (n >= 5000) stuck <= 1'b1;
  endtask : rise
  // start or repeated start: data falls while the clock is high
  task automatic start_c();
    hb();
    sda_low <= 1'b0;
    hb();
    rise();
    hb();
    sda_low <= 1'b1;
    hb();
    scl_low <= 1'b1;
  endtask : start_c
  // stop: data rises while the clock is high, bus left free
  task automatic stop_c();
    hb();
    sda_low <= 1'b1;
    hb();
    rise();
    hb();
    sda_low <= 1'b0;
    hb();
  endtask : stop_c
  // eight bits msb first, then a released ninth bit for the ack
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 8; i >= 0; i--) begin
      hb();
      sda_low <= (i > 0) ? !b[i-1] : 1'b0;
      hb();
      rise();
      hb();
      ack = !sda;
      scl_low <= 1'b1;
    end
  endtask : put_byte
endmodule : tsr_master_model
`default_nettype wire

// ==== dv/tsr_slave_rx_tb.sv ====
// self-checking bench for the two-wire slave receiver
// assumes the master model and the bound checker are compiled alongside
`timescale 1ns/100ps
`default_nettype none
`include "tsr_defines.svh"
module tsr_slave_rx_tb;
  logic core_clk;
  logic nrst;
  logic [4:0] address;
  logic read;
  logic write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic waitrequest;
  logic irq;
  logic scl_oe_n;
  logic sda_oe_n;
  logic start_launch;
  logic scl_low;
  logic sda_low;
  logic stuck;
  logic scl;
  logic sda;
  logic [31:0] rdata;
  logic [31:0] seed;
  logic [32:0] expq[$];
  logic [32:0] e;
  int fails;
  int cmp_count;
  int launches;
  ////////////////////////////////////////////////////////////////
  // open-drain lines with pull-ups
  assign scl = !scl_low && scl_oe_n;
  assign sda = !sda_low && sda_oe_n;
  tsr_slave_rx dut (.core_clk(core_clk), .nrst(nrst), .address(address), .read(read),
    .write(write), .byteenable(4'h1), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .irq(irq), .scl_in(scl), .scl_out(), .scl_oe_n(scl_oe_n),
    .sda_in(sda), .sda_out(), .sda_oe_n(sda_oe_n), .start_launch(start_launch));
  tsr_master_model bm (.core_clk(core_clk), .scl(scl), .sda(sda), .scl_low(scl_low),
    .sda_low(sda_low), .stuck(stuck));
  ////////////////////////////////////////////////////////////////
  // 25 mhz clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // compare and count
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // verdict and end of run
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out
  // xorshift step
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  // one avalon access, held until waitrequest is seen low
  task automatic bus(input logic [4:0] a, input logic w, input logic [7:0] d);
    int n;
    address <= a;
    read <= !w;
    write <= w;
    writedata <= {seed[31:8], d};
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    rdata = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge core_clk);
    if (n >= 20) begin
      fails++;
      close_out();
    end
  endtask : bus
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(a, 1'b1, d);
  endtask : wr
  // read, noting the expected word when c is set
  task automatic rd(input logic [4:0] a, input logic [31:0] x, input logic c);
    expq.push_back({c, x});
    bus(a, 1'b0, 8'h00);
  endtask : rd
  // poll the completion flag
  task automatic wait_flag();
    int n;
    n = 0;
    do begin
      rd(`TSR_REG_CTRL, 32'h0, 1'b0);
      n++;
    end while (rdata[`TSR_CTRL_FLAG] !== 1'b1 && n < 100);
    if (n >= 100) begin
      fails++;
      close_out();
    end
  endtask : wait_flag
  // one byte on the wire; st of zero means no flag is expected
  task automatic xfer(input logic [7:0] b, input logic ea, input logic [7:0] st,
                      input logic dc);
    logic ack;
    bm.put_byte(b, ack);
    check("ack", {31'h0, ack}, {31'h0, ea});
    if (st != 8'h00) begin
      wait_flag();
      check("stretch", {31'h0, scl_oe_n}, 32'h0);
      rd(`TSR_REG_STATUS, {24'h0, st}, 1'b1);
      if (dc) rd(`TSR_REG_DATA, {24'h0, b}, 1'b1);
    end
  endtask : xfer
  ////////////////////////////////////////////////////////////////
  // read monitor and start launch counter
  always @(posedge core_clk) begin
    if (start_launch === 1'b1) launches++;
    if (read === 1'b1 && waitrequest === 1'b0 && expq.size() > 0) begin
      e = expq.pop_front();
      if (e[32]) check("readdata", readdata, e[31:0]);
    end
  end
  // hang guard
  initial begin
    repeat (90000) @(posedge core_clk);
    fails++;
    close_out();
  end
  // main sequence
  initial begin
    nrst = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 5'h00;
    writedata = 32'h0;
    seed = 32'h28d4;
    fails = 0;
    cmp_count = 0;
    launches = 0;
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge core_clk);
    rd(`TSR_REG_STATUS, {24'h0, `TSR_ST_IDLE}, 1'b1);
    rd(5'h1c, 32'h0, 1'b1);
    wr(`TSR_REG_OWN, 8'h55);
    wr(`TSR_REG_RATE, seed[7:0]);
    rd(`TSR_REG_RATE, {24'h0, seed[7:0]}, 1'b1);
    wr(`TSR_REG_IRQ_MASK, 8'h01);
    wr(`TSR_REG_CTRL, 8'hc4);
    rd(`TSR_REG_OWN, 32'h55, 1'b1);
    // own address, random acked bytes, then a refused one
    bm.start_c();
    xfer(8'h54, 1'b1, `TSR_ST_SLA_ACK, 1'b0);
    check("irq", {31'h0, irq}, 32'h1);
    wr(`TSR_REG_IRQ_MASK, 8'h00);
    check("irq", {31'h0, irq}, 32'h0);
    wr(`TSR_REG_IRQ_MASK, 8'h01);
    check("irq", {31'h0, irq}, 32'h1);
    wr(`TSR_REG_IRQ_STAT, 8'h01);
    check("irq", {31'h0, irq}, 32'h0);
    repeat (3) begin
      seed = xs(seed);
      wr(`TSR_REG_CTRL, 8'hc4);
      xfer(seed[7:0], 1'b1, `TSR_ST_DATA_ACK, 1'b1);
    end
    wr(`TSR_REG_CTRL, 8'h84);
    xfer(8'h3c, 1'b0, `TSR_ST_DATA_NACK, 1'b1);
    wr(`TSR_REG_CTRL, 8'hc4);
    bm.stop_c();
    // general call still recognised, then data acked and refused
    bm.start_c();
    xfer(8'h00, 1'b1, `TSR_ST_GCA_ACK, 1'b0);
    wr(`TSR_REG_CTRL, 8'hc4);
    xfer(8'h77, 1'b1, `TSR_ST_GC_ACK, 1'b1);
    wr(`TSR_REG_CTRL, 8'h84);
    xfer(8'h11, 1'b0, `TSR_ST_GC_NACK, 1'b1);
    wr(`TSR_REG_CTRL, 8'h84);
    bm.stop_c();
    // recognition off: own address ignored
    bm.start_c();
    xfer(8'h54, 1'b0, 8'h00, 1'b0);
    bm.stop_c();
    rd(`TSR_REG_CTRL, 32'h04, 1'b1);
    // own address acked, then the data phase entered
    wr(`TSR_REG_CTRL, 8'hc4);
    bm.start_c();
    xfer(8'h54, 1'b1, `TSR_ST_SLA_ACK, 1'b0);
    wr(`TSR_REG_CTRL, 8'hc4);
    // repeated start while addressed: code a0, stretch, then a fresh address
    bm.start_c();
    wait_flag();
    rd(`TSR_REG_STATUS, {24'h0, `TSR_ST_STOP}, 1'b1);
    check("stretch", {31'h0, scl_oe_n}, 32'h0);
    wr(`TSR_REG_CTRL, 8'hc4);
    xfer(8'h54, 1'b1, `TSR_ST_SLA_ACK, 1'b0);
    wr(`TSR_REG_CTRL, 8'hc4);
    bm.stop_c();
    wait_flag();
    rd(`TSR_REG_STATUS, {24'h0, `TSR_ST_STOP}, 1'b1);
    wr(`TSR_REG_CTRL, 8'he4);
    repeat (20) @(posedge core_clk);
    check("launches", launches, 32'h1);
    rd(`TSR_REG_IRQ_STAT, 32'h3, 1'b1);
    // general call refused without its enable
    wr(`TSR_REG_OWN, 8'h54);
    bm.start_c();
    xfer(8'h00, 1'b0, 8'h00, 1'b0);
    bm.stop_c();
    check("stuck", {31'h0, stuck}, 32'h0);
    close_out();
  end
endmodule : tsr_slave_rx_tb
`default_nettype wire
